// ---- rtl/gth_params.svh ----
`ifndef GTH_PARAMS_SVH
`define GTH_PARAMS_SVH
// ==========================================================
// clock and timing
`define GTH_CLK_HZ        200000000
`define GTH_CLK_NS        5
`define GTH_PPS_LEAD_NS   20000
`define GTH_PPS_LEAD_CYC  (`GTH_PPS_LEAD_NS / `GTH_CLK_NS)
`define GTH_PPS_WIDTH_NS  10000000
`define GTH_PPS_WIDTH_CYC (`GTH_PPS_WIDTH_NS / `GTH_CLK_NS)
// ==========================================================
// spoofing thresholds
`define GTH_CNO_SPREAD_DB 8'h02
`define GTH_TIME_DIFF_NS  16'h0064
`define GTH_POS_DIFF_M    16'h001e
`define GTH_SPOOF_BIT     7
// ==========================================================
// serial, delay and pps defaults
`define GTH_BAUD_BPS      115200
`define GTH_BAUD_DIV      (`GTH_CLK_HZ / `GTH_BAUD_BPS)
`define GTH_DATA_BITS     4'h8
`define GTH_PARITY_NONE   2'h0
`define GTH_STOP_ONE      1'b0
`define GTH_DLY_DEFAULT   16'h0000
`define GTH_PPS_RISING    1'b1
// ==========================================================
// register byte offsets
`define GTH_OFS_CMD       8'h00
`define GTH_OFS_STATUS    8'h04
`define GTH_OFS_CABLE     8'h08
`define GTH_OFS_GROUP     8'h0c
`define GTH_OFS_TIMING    8'h10
`define GTH_OFS_PORTA     8'h14
`define GTH_OFS_PORTB     8'h18
`define GTH_OFS_REFPOS    8'h1c
`define GTH_OFS_ALARM     8'h20
`define GTH_OFS_EXCL      8'h24
`define GTH_OFS_PPSTIME   8'h28
// command bits
`define GTH_CMD_SAVE      0
`define GTH_CMD_POS_STORE 1
`define GTH_CMD_POS_DEL   2
`define GTH_CMD_FACTORY   3
`endif

// ---- rtl/gth_pkg.sv ----
// ==========================================================
// shared types
package gth_pkg;
`include "gth_params.svh"
    typedef enum logic [1:0] {GTH_PROTO_NONE, GTH_PROTO_BIN, GTH_PROTO_NMEA} gth_proto_type;
    typedef struct packed {
        gth_proto_type proto;
        logic          stop2;
        logic [1:0]    parity;
        logic [3:0]    data_bits;
        logic [15:0]   baud_div;
    } gth_port_type;
    typedef struct packed {
        logic [15:0]  cable_ns;
        logic [15:0]  group_ns;
        logic         pps_rising;
        gth_port_type a;
        gth_port_type b;
    } gth_cfg_type;
    typedef struct packed {
        logic          valid;
        gth_proto_type proto;
        logic          alarm;
        logic [31:0]   seconds;
    } gth_report_type;
    typedef struct packed {
        logic             update;
        logic [3:0]       tracked;
        logic [3:0][7:0]  carrier_to_noise;
        logic [3:0][15:0] time_err;
        logic [15:0]      pos_dev;
    } gth_meas_type;
    localparam gth_cfg_type GTH_CFG_DEFAULT = '{
        cable_ns: `GTH_DLY_DEFAULT, group_ns: `GTH_DLY_DEFAULT,
        pps_rising: `GTH_PPS_RISING,
        a: '{GTH_PROTO_NONE, `GTH_STOP_ONE, `GTH_PARITY_NONE, `GTH_DATA_BITS,
             16'(`GTH_BAUD_DIV)},
        b: '{GTH_PROTO_BIN, `GTH_STOP_ONE, `GTH_PARITY_NONE, `GTH_DATA_BITS,
             16'(`GTH_BAUD_DIV)}};
endpackage

// ---- rtl/gth_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gth_params.svh"
module gth_top #(
    parameter int unsigned PPS_WIDTH_CYC = `GTH_PPS_WIDTH_CYC
) (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    // avalon-mm slave
    input  wire logic [7:0]              i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    input  wire logic [3:0]              i_avs_byteenable,
    output logic [31:0]                  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // gnss engine
    input  wire gth_pkg::gth_meas_type   i_meas,
    input  wire logic                    i_epoch,
    input  wire logic [31:0]             i_epoch_seconds,
    // timing and status
    output logic                         o_pps,
    output gth_pkg::gth_report_type      o_report,
    output logic [15:0]                  o_major_alarm,
    output logic [3:0]                   o_excluded,
    output gth_pkg::gth_port_type        o_port_a,
    output gth_pkg::gth_port_type        o_port_b
);
    import gth_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] abs16(input logic [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction

    // ==========================================================
    // state
    logic           wait_r;
    logic           wr_w;
    logic           req_w;
    gth_cfg_type    cfg_r;
    gth_cfg_type    nv_cfg_r = GTH_CFG_DEFAULT;
    logic [31:0]    pos_r;
    logic [31:0]    nv_pos_r = 32'h0000_0000;
    logic           nv_pos_valid_r = 1'b0;
    logic           save_done_r;
    logic           factory_done_r;
    logic           alarm_r;
    logic [3:0]     excl_r;
    logic [3:0]     excl_w;
    logic           spoof_w;
    logic           cno_close_w;
    logic [7:0]     cno_max;
    logic [7:0]     cno_min;
    logic [2:0]     n_trk;
    logic [31:0]    rd_mux;
    logic [31:0]    cmd_w;
    logic [16:0]    comp_ns;
    logic [16:0]    dly_cyc;
    logic [16:0]    dly_cnt_r;
    logic           armed_r;
    logic [31:0]    sec_r;
    logic           pps_on_r;
    logic [23:0]    wid_cnt_r;
    logic           lead_w;

    assign req_w = (i_avs_read || i_avs_write) && wait_r;
    assign wr_w  = i_avs_write && !wait_r;
    assign cmd_w = be_merge(32'h0, i_avs_writedata, i_avs_byteenable);

    // ==========================================================
    // avalon handshake: one wait state per access
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !req_w;
        end
    end

    // read data captured in the wait cycle, zero for unmapped
    always_comb begin
        rd_mux = 32'h0;
        unique case (i_avs_address)
            `GTH_OFS_STATUS:  rd_mux = {29'h0, factory_done_r, nv_pos_valid_r, save_done_r};
            `GTH_OFS_CABLE:   rd_mux = {16'h0, cfg_r.cable_ns};
            `GTH_OFS_GROUP:   rd_mux = {16'h0, cfg_r.group_ns};
            `GTH_OFS_TIMING:  rd_mux = {31'h0, cfg_r.pps_rising};
            `GTH_OFS_PORTA:   rd_mux = {7'h0, cfg_r.a};
            `GTH_OFS_PORTB:   rd_mux = {7'h0, cfg_r.b};
            `GTH_OFS_REFPOS:  rd_mux = pos_r;
            `GTH_OFS_ALARM:   rd_mux = {16'h0, o_major_alarm};
            `GTH_OFS_EXCL:    rd_mux = {28'h0, excl_r};
            `GTH_OFS_PPSTIME: rd_mux = o_report.seconds;
            default:          rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_avs_readdata <= 32'h0;
        end else if (req_w && i_avs_read) begin
            o_avs_readdata <= rd_mux;
        end
    end
    assign o_avs_waitrequest = wait_r;

    // ==========================================================
    // live configuration: loaded from flash at reset, writes apply at once
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cfg_r <= nv_cfg_r;
        end else if (wr_w && cmd_w[`GTH_CMD_FACTORY] && i_avs_address == `GTH_OFS_CMD) begin
            cfg_r <= GTH_CFG_DEFAULT;
        end else if (wr_w) begin
            unique case (i_avs_address)
                `GTH_OFS_CABLE:  cfg_r.cable_ns <= 16'(be_merge({16'h0, cfg_r.cable_ns},
                                     i_avs_writedata, i_avs_byteenable));
                `GTH_OFS_GROUP:  cfg_r.group_ns <= 16'(be_merge({16'h0, cfg_r.group_ns},
                                     i_avs_writedata, i_avs_byteenable));
                `GTH_OFS_TIMING: if (i_avs_byteenable[0]) begin
                    cfg_r.pps_rising <= i_avs_writedata[0];
                end
                `GTH_OFS_PORTA:  cfg_r.a <= 25'(be_merge({7'h0, cfg_r.a},
                                     i_avs_writedata, i_avs_byteenable));
                `GTH_OFS_PORTB:  cfg_r.b <= 25'(be_merge({7'h0, cfg_r.b},
                                     i_avs_writedata, i_avs_byteenable));
                default: ;
            endcase
        end
    end

    // reference position, working copy
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pos_r <= nv_pos_r;
        end else if (wr_w && i_avs_address == `GTH_OFS_REFPOS) begin
            pos_r <= be_merge(pos_r, i_avs_writedata, i_avs_byteenable);
        end
    end

    // ==========================================================
    // flash image: survives reset, changed only by commands
    always_ff @(posedge i_clk) begin
        if (i_resetn && wr_w && i_avs_address == `GTH_OFS_CMD) begin
            if (cmd_w[`GTH_CMD_FACTORY]) begin
                nv_cfg_r       <= GTH_CFG_DEFAULT;
                nv_pos_valid_r <= 1'b0;
                nv_pos_r       <= 32'h0;
            end else begin
                if (cmd_w[`GTH_CMD_SAVE]) begin
                    nv_cfg_r <= cfg_r;
                end
                if (cmd_w[`GTH_CMD_POS_STORE]) begin
                    nv_pos_r       <= pos_r;
                    nv_pos_valid_r <= 1'b1;
                end else if (cmd_w[`GTH_CMD_POS_DEL]) begin
                    nv_pos_valid_r <= 1'b0;
                end
            end
        end
    end

    // command responses, cleared by the next command write
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            save_done_r    <= 1'b0;
            factory_done_r <= 1'b0;
        end else if (wr_w && i_avs_address == `GTH_OFS_CMD) begin
            save_done_r    <= cmd_w[`GTH_CMD_SAVE] && !cmd_w[`GTH_CMD_FACTORY];
            factory_done_r <= cmd_w[`GTH_CMD_FACTORY];
        end
    end

    // ==========================================================
    // spoofing detection
    generate
        for (genvar g = 0; g < 4; g++) begin : g_excl
            assign excl_w[g] = i_meas.tracked[g] &&
                               abs16(i_meas.time_err[g]) > `GTH_TIME_DIFF_NS;
        end
    endgenerate

    // spread of carrier_to_noise over tracked constellations
    always_comb begin
        cno_max = 8'h00;
        cno_min = 8'hff;
        n_trk   = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (i_meas.tracked[i]) begin
                n_trk = n_trk + 3'h1;
                if (i_meas.carrier_to_noise[i] > cno_max) cno_max = i_meas.carrier_to_noise[i];
                if (i_meas.carrier_to_noise[i] < cno_min) cno_min = i_meas.carrier_to_noise[i];
            end
        end
    end
    assign cno_close_w = (n_trk >= 3'h2) && (8'(cno_max - cno_min) <= `GTH_CNO_SPREAD_DB);
    assign spoof_w     = cno_close_w || (i_meas.pos_dev > `GTH_POS_DIFF_M);

    // alarm follows each evaluation, so it drops when criteria end
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            alarm_r <= 1'b0;
            excl_r  <= 4'h0;
        end else if (i_meas.update) begin
            alarm_r <= spoof_w;
            excl_r  <= excl_w;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_major_alarm <= 16'h0;
            o_excluded    <= 4'h0;
            o_port_a      <= GTH_CFG_DEFAULT.a;
            o_port_b      <= GTH_CFG_DEFAULT.b;
        end else begin
            o_major_alarm <= 16'(alarm_r) << `GTH_SPOOF_BIT;
            o_excluded    <= excl_r;
            o_port_a      <= cfg_r.a;
            o_port_b      <= cfg_r.b;
        end
    end

    // ==========================================================
    // pps: epoch leads the second, delays trim the remaining wait
    assign comp_ns = 17'(cfg_r.cable_ns) + 17'(cfg_r.group_ns);
    assign dly_cyc = (comp_ns >= 17'(`GTH_PPS_LEAD_NS)) ? 17'h0 :
                     17'((17'(`GTH_PPS_LEAD_NS) - comp_ns) / 17'(`GTH_CLK_NS));
    assign lead_w  = armed_r && dly_cnt_r == 17'h0;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            armed_r   <= 1'b0;
            dly_cnt_r <= 17'h0;
            sec_r     <= 32'h0;
        end else if (i_epoch) begin
            armed_r   <= 1'b1;
            dly_cnt_r <= dly_cyc;
            sec_r     <= i_epoch_seconds;
        end else if (lead_w) begin
            armed_r <= 1'b0;
        end else if (armed_r) begin
            dly_cnt_r <= dly_cnt_r - 17'h1;
        end
    end

    // pulse width and output level with chosen leading edge
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pps_on_r  <= 1'b0;
            wid_cnt_r <= 24'h0;
            o_pps     <= !GTH_CFG_DEFAULT.pps_rising;
        end else begin
            if (lead_w) begin
                pps_on_r  <= 1'b1;
                wid_cnt_r <= 24'(PPS_WIDTH_CYC - 1);
            end else if (pps_on_r && wid_cnt_r == 24'h0) begin
                pps_on_r <= 1'b0;
            end else if (pps_on_r) begin
                wid_cnt_r <= wid_cnt_r - 24'h1;
            end
            o_pps <= (lead_w || (pps_on_r && wid_cnt_r != 24'h0)) ~^ cfg_r.pps_rising;
        end
    end

    // timing report for the second just marked
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_report <= '0;
        end else begin
            o_report.valid <= lead_w;
            if (lead_w) begin
                o_report.seconds <= sec_r;
                o_report.alarm   <= alarm_r;
                o_report.proto   <= (cfg_r.b.proto == GTH_PROTO_NMEA) ? GTH_PROTO_NMEA
                                                                      : GTH_PROTO_BIN;
            end
        end
    end

    // ==========================================================
    // checks
    a_alarm_bit_seven: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_meas.update && spoof_w |=> ##1 o_major_alarm[7])
        else $error("spoof alarm missing on bit 7");
    a_cno_close_alarm: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_meas.update && cno_close_w |=> alarm_r)
        else $error("close carrier_to_noise not alarmed");
    a_time_excluded: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_meas.update && i_meas.tracked[2] && ($signed(i_meas.time_err[2]) > 16'sh0064 ||
        $signed(i_meas.time_err[2]) < -16'sh0064)
        |=> ##1 o_excluded[2])
        else $error("offset constellation not excluded");
    a_pos_dev_alarm: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_meas.update && i_meas.pos_dev > 16'h001e |=> alarm_r)
        else $error("position departure not alarmed");
    a_alarm_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_meas.update && !spoof_w |=> ##1 !o_major_alarm[7])
        else $error("spoof alarm not cleared");
    a_pps_leading: assert property (@(posedge i_clk) disable iff (!i_resetn)
        lead_w |=> o_pps == cfg_r.pps_rising && o_report.valid)
        else $error("pps leading edge wrong");
    // cycles since the last epoch while its timing report is still owed
    logic [12:0] rpt_wait_r;
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rpt_wait_r <= 13'h0;
        end else if (i_epoch) begin
            rpt_wait_r <= 13'h1;
        end else if (o_report.valid) begin
            rpt_wait_r <= 13'h0;
        end else if (rpt_wait_r != 13'h0 && rpt_wait_r != 13'h1fff) begin
            rpt_wait_r <= rpt_wait_r + 13'h1;
        end
    end
    a_report_once: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rpt_wait_r <= 13'(`GTH_PPS_LEAD_CYC + 2))
        else $error("no timing report after epoch");
    a_write_no_flash: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_w && i_avs_address == `GTH_OFS_CABLE && i_avs_byteenable == 4'hf
        |=> cfg_r.cable_ns == $past(i_avs_writedata[15:0]) && $stable(nv_cfg_r))
        else $error("config write not live or stored early");
    a_save_copies: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_w && i_avs_address == `GTH_OFS_CMD && cmd_w[0] && !cmd_w[3]
        |=> nv_cfg_r == $past(cfg_r) && save_done_r)
        else $error("save did not copy config");
    a_factory_erase: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_w && i_avs_address == `GTH_OFS_CMD && cmd_w[3]
        |=> !nv_pos_valid_r && cfg_r == GTH_CFG_DEFAULT)
        else $error("factory reset incomplete");
endmodule
`default_nettype wire

// ---- sim/gth_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side: derives time of day from timing reports
module gth_host_model (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    // timing reports from the device
    input  wire gth_pkg::gth_report_type i_report,
    // derived time
    output logic [31:0]                  o_now,
    output logic                         o_trusted
);
    import gth_pkg::*;
    logic [31:0] cap_r;
    logic        armed_r;
    // take the time from timing reports only; one second later at the next pulse
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cap_r     <= 32'h0;
            armed_r   <= 1'b0;
            o_now     <= 32'h0;
            o_trusted <= 1'b0;
        end else if (i_report.valid) begin
            cap_r     <= i_report.seconds;
            armed_r   <= 1'b1;
            if (armed_r) begin
                o_now <= cap_r + 32'h1;
            end
            o_trusted <= !i_report.alarm;
        end
    end
endmodule
`default_nettype wire

// ---- sim/test_gth_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gth_params.svh"
// ==========================================================
// bench for the timing host block
module test_gth_top;
    import gth_pkg::*;
    localparam int unsigned PPS_W = 16;
    logic          i_clk = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [7:0]    i_avs_address = 8'h00;
    logic [31:0]   i_avs_writedata = 32'h0, i_epoch_seconds = 32'h0, o_avs_readdata, q;
    logic [3:0]    i_avs_byteenable = 4'hf, o_excluded;
    logic          o_avs_waitrequest, i_epoch = 1'b0, o_pps, host_trusted;
    logic [15:0]   o_major_alarm;
    logic [31:0]   host_now;
    gth_meas_type  i_meas = '0;
    gth_report_type o_report;
    gth_port_type  o_port_a, o_port_b;
    int            err_total = 0, samples_checked = 0, cycles = 0;
    gth_top #(.PPS_WIDTH_CYC(PPS_W)) u_dut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_meas(i_meas), .i_epoch(i_epoch), .i_epoch_seconds(i_epoch_seconds),
        .o_pps(o_pps), .o_report(o_report), .o_major_alarm(o_major_alarm),
        .o_excluded(o_excluded), .o_port_a(o_port_a), .o_port_b(o_port_b));
    gth_host_model u_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_report(o_report),
        .o_now(host_now), .o_trusted(host_trusted));
    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;
    // ==========================================================
    // run limit
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // avalon master: hold request until waitrequest is sampled low
    task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        @(posedge i_clk);
        i_avs_read      <= !wr;
        i_avs_write     <= wr;
        i_avs_address   <= a;
        i_avs_writedata <= d;
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_defaults();
        av(0, `GTH_OFS_PORTA, 32'h0, q);
        chk("port a", {7'h0, 2'h0, 3'h0, `GTH_DATA_BITS, 16'(`GTH_BAUD_DIV)}, q);
        av(0, `GTH_OFS_PORTB, 32'h0, q);
        chk("port b", {7'h0, 2'h1, 3'h0, `GTH_DATA_BITS, 16'(`GTH_BAUD_DIV)}, q);
        av(0, 8'h40, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("test defaults done");
    endtask
    task automatic t_config();
        av(1, `GTH_OFS_PORTA, 32'h01180364, q);
        @(posedge i_clk);
        #1;
        chk("live baud", 32'h0364, {16'h0, o_port_a.baud_div});
        do_reset();
        av(0, `GTH_OFS_PORTA, 32'h0, q);
        chk("unsaved lost", 32'h000806c8, q);
        av(1, `GTH_OFS_PORTB, 32'h01080364, q);
        av(1, `GTH_OFS_CMD, 32'h1, q);
        av(0, `GTH_OFS_STATUS, 32'h0, q);
        chk("save status", 32'h1, q);
        do_reset();
        av(0, `GTH_OFS_PORTB, 32'h0, q);
        chk("saved kept", 32'h01080364, q);
        av(1, `GTH_OFS_CMD, 32'h2, q);
        av(0, `GTH_OFS_STATUS, 32'h0, q);
        chk("pos stored", 32'h2, q);
        av(1, `GTH_OFS_CMD, 32'h8, q);
        av(0, `GTH_OFS_STATUS, 32'h0, q);
        chk("factory status", 32'h4, q);
        av(0, `GTH_OFS_PORTB, 32'h0, q);
        chk("factory port", 32'h008806c8, q);
        chk("port b out", 32'h008806c8, {7'h0, o_port_b});
        $display("test config done");
    endtask
    task automatic meas(input logic [31:0] carrier_to_noise, input logic [15:0] te, input logic [1:0] k,
                        input logic [15:0] pos, input logic [15:0] ea, input logic [3:0] ex);
        logic [3:0][15:0] te_v;
        te_v    = '0;
        te_v[k] = te;
        @(posedge i_clk);
        i_meas.update   <= 1'b1;
        i_meas.tracked  <= 4'hf;
        i_meas.carrier_to_noise      <= carrier_to_noise;
        i_meas.time_err <= te_v;
        i_meas.pos_dev  <= pos;
        @(posedge i_clk);
        i_meas.update <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("major alarm", {16'h0, ea}, {16'h0, o_major_alarm});
        chk("excluded", {28'h0, ex}, {28'h0, o_excluded});
    endtask
    task automatic t_spoof();
        meas(32'h28292a28, 16'h0, 2'd0, 16'h0, 16'h0080, 4'h0);
        meas(32'h282b2828, 16'h0, 2'd0, 16'h0, 16'h0000, 4'h0);
        meas(32'h10302050, 16'h0, 2'd0, 16'h001f, 16'h0080, 4'h0);
        av(0, `GTH_OFS_ALARM, 32'h0, q);
        chk("alarm reg", 32'h80, q);
        meas(32'h10302050, 16'h0, 2'd0, 16'h001e, 16'h0000, 4'h0);
        meas(32'h10302050, 16'h0065, 2'd2, 16'h0, 16'h0000, 4'h4);
        meas(32'h10302050, 16'hff9b, 2'd1, 16'h0, 16'h0000, 4'h2);
        meas(32'h10302050, 16'h0064, 2'd3, 16'h0, 16'h0000, 4'h0);
        av(1, `GTH_OFS_ALARM, 32'hffffffff, q);
        av(0, `GTH_OFS_ALARM, 32'h0, q);
        chk("alarm read only", 32'h0, q);
        $display("test spoof done");
    endtask
    task automatic t_pps(input logic [15:0] cab, input logic [15:0] grp, input logic rise,
                         input logic [31:0] sec);
        int d;
        int n;
        d = (`GTH_PPS_LEAD_NS - cab - grp) / `GTH_CLK_NS;
        n = 1;
        av(1, `GTH_OFS_CABLE, {16'h0, cab}, q);
        av(1, `GTH_OFS_GROUP, {16'h0, grp}, q);
        av(1, `GTH_OFS_TIMING, {31'h0, rise}, q);
        repeat (PPS_W + 4) @(posedge i_clk);
        #1;
        chk("pps idle", {31'h0, !rise}, {31'h0, o_pps});
        @(posedge i_clk);
        i_epoch         <= 1'b1;
        i_epoch_seconds <= sec;
        @(posedge i_clk);
        i_epoch <= 1'b0;
        #1;
        while (o_pps !== rise && n < 30000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("pps lead cycle", 32'(d + 2), 32'(n));
        chk("report valid", 32'h1, {31'h0, o_report.valid});
        chk("report seconds", sec, o_report.seconds);
        chk("report proto", 32'(GTH_PROTO_BIN), 32'(o_report.proto));
        chk("report alarm", 32'h0, {31'h0, o_report.alarm});
        repeat (PPS_W - 1) @(posedge i_clk);
        #1;
        chk("pps width", {31'h0, rise}, {31'h0, o_pps});
        @(posedge i_clk);
        #1;
        chk("pps end", {31'h0, !rise}, {31'h0, o_pps});
        $display("test pps done");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        t_defaults();
        t_config();
        t_spoof();
        t_pps(16'd100, 16'd0, 1'b1, 32'h00001000);
        t_pps(16'd100, 16'd200, 1'b0, 32'h00001001);
        chk("host time", 32'h00001001, host_now);
        chk("host trust", 32'h1, {31'h0, host_trusted});
        av(0, `GTH_OFS_PPSTIME, 32'h0, q);
        chk("pps time reg", 32'h00001001, q);
        print_verdict();
    end
endmodule
`default_nettype wire
